// [cerpt_top.v]
// What this block does
// - emcy mask selects which fault causes are reported by emcy
// - emcy frames only go out while emcy reporting is enabled
// - emcy mask resets to zero so nothing reports until written
// - each cause bit maps to a fixed 16-bit emcy error code
// - limit switches report 5441h, 5442h; interlock bit 28 reports 5444h
// - mask sub 1 read/write, 2 sets ones, 3 clears ones, 0 reads 3
// - reported-errors register latches every non-reserved fault regardless of masks
// - master may set reported bits for test or clear backlog
// - sending a fault-cleared emcy frame clears the reported bit
// - bits 27, 29, 30 reserved; bit 31 is user fault via set entry
// - reported sub 1 read/write, 2 sets, 3 clears, 0 reads 3
// - writing trigger sub n fires transmit pdo n, value ignored
// - trigger serves pdo types 0 and the two event types
// - trigger from program or bus; write-only; sub 0 reads 4
// - reported error enabled in critical mask sets status word two bit 10
`default_nettype none
`include "cerpt_defs.vh"

module cerpt_top
#(
  parameter NCAUSE = 32
)
(
  input  wire              clk,            // 250 mhz clock
  input  wire              rstn,           // async reset, active low
  // dictionary access from sdo server or local program
  input  wire              dict_wr,        // write strobe, one cycle
  input  wire              dict_rd,        // read strobe, one cycle
  input  wire [15:0]       dict_index,     // object index
  input  wire [7:0]        dict_sub,       // sub-entry
  input  wire [31:0]       dict_wdata,     // write data
  output reg  [31:0]       dict_rdata,     // read data, registered
  output reg               dict_ack,       // access done, one cycle
  output reg               dict_abort,     // access refused, one cycle
  // fault sources and configuration
  input  wire [NCAUSE-1:0] fault_active,   // live fault causes
  input  wire [NCAUSE-1:0] critical_mask,  // critical-error mask
  input  wire              emcy_enable,    // emcy reporting enabled
  // emcy frame request to the can transmitter
  output reg               emcy_valid,     // frame pending
  output reg  [15:0]       emcy_code,      // error code, zero if cleared
  output reg  [4:0]        emcy_cause,     // cause bit of frame
  output reg               emcy_kind,      // 1 raised, 0 cleared
  input  wire              emcy_done,      // frame sent successfully
  // pdo triggers and status
  output reg  [3:0]        tpdo_trigger,   // fire tpdo n, one cycle pulse
  output wire [31:0]       emcy_mask,      // current emcy report mask
  output wire [31:0]       reported_errs,  // reported-errors register
  output reg  [15:0]       internal_status_word_two // status word two
);

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire is_mask = (dict_index == `CERPT_IDX_EMCY_MASK);
  wire is_rep  = (dict_index == `CERPT_IDX_REPORTED);
  wire is_trig = (dict_index == `CERPT_IDX_TRIGGER);

  wire sub_rw  = (dict_sub == `CERPT_SUB_RW);
  wire sub_set = (dict_sub == `CERPT_SUB_SET);
  wire sub_clr = (dict_sub == `CERPT_SUB_CLEAR);
  wire sub_cnt = (dict_sub == `CERPT_SUB_COUNT);
  wire sub_trg = (dict_sub >= `CERPT_SUB_TRIG_FIRST) &&
                 (dict_sub <= `CERPT_SUB_TRIG_LAST);

  wire wr_ok = dict_wr && ((is_mask || is_rep) && (sub_rw || sub_set ||
               sub_clr) || is_trig && sub_trg);
  wire rd_ok = dict_rd && ((is_mask || is_rep) && (sub_cnt || sub_rw) ||
               is_trig && sub_cnt);

  // ------------------------------------------------------------
  // emcy report mask
  // ------------------------------------------------------------
  // mask sub-entries
  // resets to zero inside the register
  cerpt_sc_reg #(.WIDTH(32)) u_mask
  (
    .clk    (clk),
    .rstn   (rstn),
    .wr_full(dict_wr && is_mask && sub_rw),
    .wr_set (dict_wr && is_mask && sub_set),
    .wr_clr (dict_wr && is_mask && sub_clr),
    .wdata  (dict_wdata),
    .hw_set (32'h0000_0000),
    .hw_clr (32'h0000_0000),
    .q_reg  (emcy_mask)
  );

  // ------------------------------------------------------------
  // reported errors
  // ------------------------------------------------------------
  reg  [NCAUSE-1:0] fault_prev_reg;
  wire [31:0]       fault_rise;
  wire [31:0]       fault_fall;
  wire [31:0]       sent_clear;

  // every rising non-reserved fault latches, masks ignored
  assign fault_rise = fault_active & ~fault_prev_reg &
                      ~`CERPT_RESERVED_BITS;
  assign fault_fall = ~fault_active & fault_prev_reg;

  // sent cleared frame removes its bit
  assign sent_clear = (emcy_valid && emcy_done &&
                       emcy_kind == `CERPT_EMCY_CLEARED) ?
                      (32'h0000_0001 << emcy_cause) : 32'h0000_0000;

  // reserved bits never set by writes
  cerpt_sc_reg #(.WIDTH(32)) u_rep
  (
    .clk    (clk),
    .rstn   (rstn),
    .wr_full(dict_wr && is_rep && sub_rw),
    .wr_set (dict_wr && is_rep && sub_set),
    .wr_clr (dict_wr && is_rep && sub_clr),
    .wdata  (dict_wdata & ~`CERPT_RESERVED_BITS),
    .hw_set (fault_rise),
    .hw_clr (sent_clear),
    .q_reg  (reported_errs)
  );

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      fault_prev_reg <= {NCAUSE{1'b0}};
    else
      fault_prev_reg <= fault_active;
  end

  // ------------------------------------------------------------
  // emcy request queue
  // ------------------------------------------------------------
  // one pending bit per cause for raised, one for cleared frames
  reg  [31:0] rep_prev_reg;
  reg  [31:0] pend_raise_reg;
  reg  [31:0] pend_clear_reg;
  reg  [31:0] pend_raise_next;
  reg  [31:0] pend_clear_next;
  wire [31:0] rep_new = reported_errs & ~rep_prev_reg;
  wire [31:0] eligible = emcy_mask & {32{emcy_enable}};

  always @*
  begin
    pend_raise_next = pend_raise_reg;
    pend_clear_next = pend_clear_reg;
    if (emcy_valid && emcy_done)
    begin
      if (emcy_kind == `CERPT_EMCY_RAISED)
        pend_raise_next[emcy_cause] = 1'b0;
      else
        pend_clear_next[emcy_cause] = 1'b0;
    end
    // new masked bit queues one frame
    pend_raise_next = pend_raise_next | (rep_new & eligible);
    pend_clear_next = pend_clear_next |
                      (fault_fall & reported_errs & eligible);
    // backlog cleared by software is not reported
    pend_raise_next = pend_raise_next & reported_errs;
    pend_clear_next = pend_clear_next & reported_errs;
  end

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rep_prev_reg   <= `CERPT_REPORTED_RESET;
      pend_raise_reg <= 32'h0000_0000;
      pend_clear_reg <= 32'h0000_0000;
    end
    else
    begin
      rep_prev_reg   <= reported_errs;
      pend_raise_reg <= pend_raise_next;
      pend_clear_reg <= pend_clear_next;
    end
  end

  // lowest cause first; frame held stable until emcy_done
  reg  [4:0] pick_idx;
  reg        pick_kind;
  reg        pick_any;
  integer    i;

  always @*
  begin
    pick_idx  = 5'h00;
    pick_kind = `CERPT_EMCY_RAISED;
    pick_any  = 1'b0;
    for (i = 31; i >= 0; i = i - 1)
    begin
      if (pend_raise_reg[i] || pend_clear_reg[i])
      begin
        pick_idx  = i[4:0];
        pick_kind = pend_raise_reg[i];
        pick_any  = 1'b1;
      end
    end
  end

  wire [15:0] pick_code;
  cerpt_code_rom u_rom
  (
    .cause(pick_idx),
    .code (pick_code)
  );

  localparam ST_IDLE = 1'b0;
  localparam ST_SEND = 1'b1;
  reg state_reg;

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg  <= ST_IDLE;
      emcy_valid <= 1'b0;
      emcy_code  <= 16'h0000;
      emcy_cause <= 5'h00;
      emcy_kind  <= `CERPT_EMCY_RAISED;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          // queue waits while reporting is off
          if (pick_any && emcy_enable)
          begin
            state_reg  <= ST_SEND;
            emcy_valid <= 1'b1;
            emcy_cause <= pick_idx;
            emcy_kind  <= pick_kind;
            emcy_code  <= pick_kind ? pick_code : 16'h0000;
          end
        end
        ST_SEND:
        begin
          if (emcy_done)
          begin
            state_reg  <= ST_IDLE;
            emcy_valid <= 1'b0;
          end
        end
        default:
        begin
          state_reg  <= ST_IDLE;
          emcy_valid <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // status word two, pdo triggers, access answers
  // ------------------------------------------------------------
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      internal_status_word_two <= `CERPT_STATUS_RESET;
      tpdo_trigger             <= 4'h0;
      dict_ack                 <= 1'b0;
      dict_abort               <= 1'b0;
      dict_rdata               <= 32'h0000_0000;
    end
    else
    begin
      internal_status_word_two[`CERPT_CAN_ERROR_BIT] <=
        |(reported_errs & critical_mask);
      // type selection is the pdo scheduler's
      tpdo_trigger <= 4'h0;
      if (dict_wr && is_trig && sub_trg)
        tpdo_trigger <= 4'h1 << (dict_sub[1:0] - 2'h1);
      dict_ack   <= wr_ok || rd_ok;
      dict_abort <= (dict_wr && !wr_ok) || (dict_rd && !rd_ok);
      if (dict_rd)
      begin
        dict_rdata <= 32'h0000_0000;
        if (is_mask && sub_cnt)
          dict_rdata <= `CERPT_MASK_COUNT;
        else if (is_mask && sub_rw)
          dict_rdata <= emcy_mask;
        else if (is_rep && sub_cnt)
          dict_rdata <= `CERPT_REPORTED_COUNT;
        else if (is_rep && sub_rw)
          dict_rdata <= reported_errs;
        else if (is_trig && sub_cnt)
          dict_rdata <= `CERPT_TRIGGER_COUNT;
      end
    end
  end

endmodule
`default_nettype wire

// [cerpt_defs.vh]
`ifndef CERPT_DEFS_VH
`define CERPT_DEFS_VH

// ------------------------------------------------------------
// dictionary indices and sub-entries
// ------------------------------------------------------------
`define CERPT_IDX_EMCY_MASK   16'h2001
`define CERPT_IDX_REPORTED    16'h2002
`define CERPT_IDX_TRIGGER     16'h2003
`define CERPT_SUB_COUNT       8'h00
`define CERPT_SUB_RW          8'h01
`define CERPT_SUB_SET         8'h02
`define CERPT_SUB_CLEAR       8'h03
`define CERPT_SUB_TRIG_FIRST  8'h01
`define CERPT_SUB_TRIG_LAST   8'h04

// ------------------------------------------------------------
// constant reads and reset values
// ------------------------------------------------------------
`define CERPT_MASK_COUNT      32'h0000_0003
`define CERPT_REPORTED_COUNT  32'h0000_0003
`define CERPT_TRIGGER_COUNT   32'h0000_0004
`define CERPT_MASK_RESET      32'h0000_0000
`define CERPT_REPORTED_RESET  32'h0000_0000
`define CERPT_STATUS_RESET    16'h0000

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CERPT_CAN_ERROR_BIT   10
`define CERPT_USER_FAULT_BIT  31
`define CERPT_RESERVED_BITS   32'h6800_0000

// ------------------------------------------------------------
// emcy frame kinds
// ------------------------------------------------------------
`define CERPT_EMCY_RAISED     1'b1
`define CERPT_EMCY_CLEARED    1'b0

`endif

// [cerpt_code_rom.v]
`default_nettype none
`include "cerpt_defs.vh"

// ------------------------------------------------------------
// fixed emcy error code per fault cause
// ------------------------------------------------------------
module cerpt_code_rom
(
  input  wire [4:0]  cause,   // fault cause index
  output reg  [15:0] code     // emcy error code
);

  always @*
  begin
    case (cause)
      5'h00: code = 16'h4310;
      5'h01: code = 16'h3210;
      5'h02: code = 16'h3120;
      5'h03: code = 16'h4000;
      5'h04: code = 16'h7305;
      5'h05: code = 16'h7122;
      5'h06: code = 16'h5530;
      5'h07: code = 16'h6320;
      5'h08: code = 16'h8611;
      5'h09: code = 16'h8612;
      5'h0a: code = 16'h6200;
      5'h0b: code = 16'h8130;
      5'h0c: code = 16'h8120;
      5'h0d: code = 16'h8200;
      5'h0e: code = 16'h3000;
      5'h0f: code = 16'h5440;
      5'h10: code = 16'h8400;
      5'h11: code = 16'h8210;
      5'h12: code = 16'h8211;
      5'h13: code = 16'h4110;
      5'h14: code = 16'h8140;
      5'h15: code = 16'hf001;
      5'h16: code = 16'hf002;
      5'h17: code = 16'hf003;
      5'h18: code = 16'hf004;
      5'h19: code = 16'h5441;
      5'h1a: code = 16'h5442;
      5'h1b: code = 16'h5443;
      5'h1c: code = 16'h5444;
      5'h1d: code = 16'h5445;
      5'h1e: code = 16'h5446;
      default: code = 16'h5447;
    endcase
  end

endmodule
`default_nettype wire

// [cerpt_sc_reg.v]
`default_nettype none
`include "cerpt_defs.vh"

// ------------------------------------------------------------
// 32-bit register with write, set-ones and clear-ones access
// ------------------------------------------------------------
module cerpt_sc_reg
#(
  parameter WIDTH = 32
)
(
  input  wire             clk,      // system clock
  input  wire             rstn,     // async reset, active low
  input  wire             wr_full,  // full write
  input  wire             wr_set,   // set ones written
  input  wire             wr_clr,   // clear ones written
  input  wire [WIDTH-1:0] wdata,    // write data
  input  wire [WIDTH-1:0] hw_set,   // hardware set, wins over clear
  input  wire [WIDTH-1:0] hw_clr,   // hardware clear
  output reg  [WIDTH-1:0] q_reg     // register value
);

  reg [WIDTH-1:0] q_next;

  always @*
  begin
    q_next = q_reg;
    if (wr_full)
      q_next = wdata;
    if (wr_set)
      q_next = q_next | wdata;
    if (wr_clr)
      q_next = q_next & ~wdata;
    q_next = (q_next & ~hw_clr) | hw_set;
  end

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      q_reg <= {WIDTH{1'b0}};
    else
      q_reg <= q_next;
  end

endmodule
`default_nettype wire

// [cerpt_top_sva.sv]
`default_nettype none
module cerpt_top_sva
#(
  parameter NCAUSE = 32
)
(
  input wire logic              clk,          // clock
  input wire logic              rstn,         // reset
  input wire logic              dict_wr,      // write
  input wire logic              dict_rd,      // read
  input wire logic [15:0]       dict_index,   // index
  input wire logic [7:0]        dict_sub,     // sub
  input wire logic              dict_ack,     // accepted
  input wire logic              dict_abort,   // refused
  input wire logic [NCAUSE-1:0] fault_active, // faults
  input wire logic              emcy_valid,   // pending
  input wire logic [15:0]       emcy_code,    // code
  input wire logic              emcy_kind,    // kind
  input wire logic              emcy_done,    // sent
  input wire logic [3:0]        tpdo_trigger, // pulses
  input wire logic [31:0]       emcy_mask,    // mask
  input wire logic [31:0]       reported_errs // errors
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // helper: fault rises, reserved bits never latch
  // ------------------------------------------------------------
  logic [NCAUSE-1:0] fault_prev_reg;
  wire logic [NCAUSE-1:0] rise = fault_active & ~fault_prev_reg &
                                 ~32'h6800_0000;

  always @(posedge clk or negedge rstn)
    if (!rstn)
      fault_prev_reg <= '0;
    else
      fault_prev_reg <= fault_active;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_access_answer: assert property (
    (dict_ack | dict_abort) == ($past(dict_wr) | $past(dict_rd)) &&
    !(dict_ack && dict_abort)) else $error("access answer wrong");
  a_trigger_fires: assert property (
    dict_wr && dict_index == 16'h2003 && dict_sub >= 8'h01 &&
    dict_sub <= 8'h04 |=> tpdo_trigger ==
    4'h1 << ($past(dict_sub[1:0]) - 2'h1)) else $error("no tpdo pulse");
  a_trigger_quiet: assert property (
    !(dict_wr && dict_index == 16'h2003) |=> tpdo_trigger == 4'h0)
    else $error("stray tpdo pulse");
  a_mask_holds: assert property (
    !dict_wr |=> $stable(emcy_mask)) else $error("mask changed");
  a_fault_latch: assert property (
    rise != '0 |=> (reported_errs & $past(rise)) == $past(rise))
    else $error("fault not latched");
  a_reserved_zero: assert property (
    (reported_errs & 32'h6800_0000) == 32'h0) else $error("reserved set");
  a_frame_holds: assert property (
    emcy_valid && !emcy_done |=> emcy_valid && $stable(emcy_code) &&
    $stable(emcy_kind)) else $error("frame dropped early");
  a_frame_ends: assert property (
    emcy_valid && emcy_done |=> !emcy_valid) else $error("frame stuck");
endmodule

bind cerpt_top cerpt_top_sva #(.NCAUSE(NCAUSE)) u_sva
(
  .clk(clk), .rstn(rstn), .dict_wr(dict_wr), .dict_rd(dict_rd),
  .dict_index(dict_index), .dict_sub(dict_sub), .dict_ack(dict_ack),
  .dict_abort(dict_abort), .fault_active(fault_active),
  .emcy_valid(emcy_valid), .emcy_code(emcy_code), .emcy_kind(emcy_kind),
  .emcy_done(emcy_done), .tpdo_trigger(tpdo_trigger),
  .emcy_mask(emcy_mask), .reported_errs(reported_errs)
);
`default_nettype wire

// [cerpt_can_tx_model.sv]
`default_nettype none
module cerpt_can_tx_model
(
  input  wire logic       clk,        // clock
  input  wire logic       rstn,       // reset
  input  wire logic       emcy_valid, // frame pending
  input  wire logic [3:0] tx_delay,   // cycles to win the bus
  output var  logic       emcy_done   // frame sent
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wait_reg;

  // success ends frame
  // arbitration may lose several times, so success can lag
  always @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      wait_reg  <= 4'h0;
      emcy_done <= 1'b0;
    end
    else if (emcy_valid && !emcy_done && wait_reg >= tx_delay)
    begin
      wait_reg  <= 4'h0;
      emcy_done <= 1'b1;
    end
    else
    begin
      wait_reg  <= (emcy_valid && !emcy_done) ? wait_reg + 4'h1 : 4'h0;
      emcy_done <= 1'b0;
    end
endmodule
`default_nettype wire

// [cerpt_top_bench.sv]
`default_nettype none
module cerpt_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        dict_wr = 1'b0;
  logic        dict_rd = 1'b0;
  logic [15:0] dict_index = 16'h0;
  logic [7:0]  dict_sub = 8'h0;
  logic [31:0] dict_wdata = 32'h0;
  logic [31:0] fault_active = 32'h0;
  logic [31:0] critical_mask = 32'h0;
  logic        emcy_enable = 1'b0;
  logic [3:0]  tx_delay = 4'h0;
  wire  [31:0] dict_rdata, emcy_mask, reported_errs;
  wire         dict_ack, dict_abort, emcy_valid, emcy_kind, emcy_done;
  wire  [15:0] emcy_code, status_word;
  wire  [4:0]  emcy_cause;
  wire  [3:0]  tpdo_trigger;
  int          checked = 0;
  int          mismatches = 0;
  int          cycles = 0;
  int          k;
  logic [21:0] fq [$];
  logic [15:0] codes [32] = '{
    16'h4310, 16'h3210, 16'h3120, 16'h4000, 16'h7305, 16'h7122, 16'h5530,
    16'h6320, 16'h8611, 16'h8612, 16'h6200, 16'h8130, 16'h8120, 16'h8200,
    16'h3000, 16'h5440, 16'h8400, 16'h8210, 16'h8211, 16'h4110, 16'h8140,
    16'hf001, 16'hf002, 16'hf003, 16'hf004, 16'h5441, 16'h5442, 16'h5443,
    16'h5444, 16'h5445, 16'h5446, 16'h5447};

  cerpt_top dut
  (
    .clk(clk), .rstn(rstn), .dict_wr(dict_wr), .dict_rd(dict_rd),
    .dict_index(dict_index), .dict_sub(dict_sub), .dict_wdata(dict_wdata),
    .dict_rdata(dict_rdata), .dict_ack(dict_ack), .dict_abort(dict_abort),
    .fault_active(fault_active), .critical_mask(critical_mask),
    .emcy_enable(emcy_enable), .emcy_valid(emcy_valid),
    .emcy_code(emcy_code), .emcy_cause(emcy_cause), .emcy_kind(emcy_kind),
    .emcy_done(emcy_done), .tpdo_trigger(tpdo_trigger),
    .emcy_mask(emcy_mask), .reported_errs(reported_errs),
    .internal_status_word_two(status_word)
  );

  cerpt_can_tx_model can_tx
  (
    .clk(clk), .rstn(rstn), .emcy_valid(emcy_valid),
    .tx_delay(tx_delay), .emcy_done(emcy_done)
  );

  always #2 clk = ~clk;

  // ------------------------------------------------------------
  // frame log and hang guard
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    cycles++;
    if (emcy_valid && emcy_done)
      fq.push_back({emcy_kind, emcy_cause, emcy_code});
    if (cycles == 5000)
    begin
      mismatches++;
      test_done;
    end
  end

  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one strobe, answer sampled in the cycle after it stands
  task automatic acc(input logic wr, input logic [15:0] idx,
                     input logic [7:0] sub, input logic [31:0] d,
                     input logic refused, input logic [31:0] exp);
    @(posedge clk);
    dict_wr    <= wr;
    dict_rd    <= !wr;
    dict_index <= idx;
    dict_sub   <= sub;
    dict_wdata <= d;
    @(posedge clk);
    dict_wr <= 1'b0;
    dict_rd <= 1'b0;
    #1;
    check("answer", {dict_ack, dict_abort}, {!refused, refused});
    if (!wr && !refused)
      check("read", dict_rdata, exp);
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    acc(1'b0, 16'h2001, 8'h00, 32'h0, 1'b0, 32'h3);
    acc(1'b0, 16'h2002, 8'h00, 32'h0, 1'b0, 32'h3);
    acc(1'b0, 16'h2003, 8'h00, 32'h0, 1'b0, 32'h4);
    acc(1'b0, 16'h2001, 8'h01, 32'h0, 1'b0, 32'h0);
    acc(1'b1, 16'h2001, 8'h01, 32'h0000_ffff, 1'b0, 32'h0);
    acc(1'b1, 16'h2001, 8'h02, 32'h0f00_0000, 1'b0, 32'h0);
    acc(1'b1, 16'h2001, 8'h03, 32'h0000_00f0, 1'b0, 32'h0);
    acc(1'b1, 16'h2001, 8'h00, 32'h0, 1'b1, 32'h0);
    acc(1'b1, 16'h2005, 8'h01, 32'h0, 1'b1, 32'h0);
    acc(1'b0, 16'h2001, 8'h02, 32'h0, 1'b1, 32'h0);
    acc(1'b0, 16'h2001, 8'h01, 32'h0, 1'b0, 32'h0f00_ff0f);
    check("mask", emcy_mask, 32'h0f00_ff0f);
    acc(1'b1, 16'h2002, 8'h01, 32'hffff_ffff, 1'b0, 32'h0);
    acc(1'b0, 16'h2002, 8'h01, 32'h0, 1'b0, 32'h97ff_ffff);
    acc(1'b1, 16'h2002, 8'h03, 32'h17ff_ffff, 1'b0, 32'h0);
    acc(1'b0, 16'h2002, 8'h03, 32'h0, 1'b1, 32'h0);
    acc(1'b0, 16'h2002, 8'h01, 32'h0, 1'b0, 32'h8000_0000);
    @(posedge clk);
    critical_mask <= 32'h8000_0000;
    settle(4);
    check("status", status_word, 16'h0400);
    @(posedge clk);
    critical_mask <= 32'h7fff_ffff;
    settle(4);
    check("status", status_word, 16'h0000);
    acc(1'b1, 16'h2002, 8'h03, 32'hffff_ffff, 1'b0, 32'h0);
    acc(1'b1, 16'h2002, 8'h02, 32'h8000_0000, 1'b0, 32'h0);
    check("user bit", reported_errs, 32'h8000_0000);
    acc(1'b1, 16'h2002, 8'h01, 32'h0, 1'b0, 32'h0);
    acc(1'b1, 16'h2001, 8'h01, 32'h1, 1'b0, 32'h0);
    @(posedge clk);
    fault_active <= 32'h1;
    settle(6);
    check("latched", reported_errs, 32'h1);
    acc(1'b1, 16'h2001, 8'h01, 32'h0, 1'b0, 32'h0);
    @(posedge clk);
    emcy_enable  <= 1'b1;
    fault_active <= 32'h2;
    settle(6);
    check("latched", reported_errs, 32'h3);
    check("frames", fq.size(), 0);
    @(posedge clk);
    fault_active <= 32'h0;
    acc(1'b1, 16'h2002, 8'h03, 32'h3, 1'b0, 32'h0);
    check("backlog", reported_errs, 32'h0);
    for (int n = 1; n <= 4; n++)
    begin
      acc(1'b1, 16'h2003, 8'(n), 32'ha5a5_0000 + n, 1'b0, 32'h0);
      check("trigger", tpdo_trigger, 4'h1 << (n - 1));
    end
    acc(1'b0, 16'h2003, 8'h01, 32'h0, 1'b1, 32'h0);
    check("trigger", tpdo_trigger, 4'h0);
    acc(1'b1, 16'h2003, 8'h05, 32'h0, 1'b1, 32'h0);
    acc(1'b1, 16'h2001, 8'h01, 32'hffff_ffdf, 1'b0, 32'h0);
    // all causes rise: 29 latch (reserved excluded, user bit 31 included), 28 frames with bit 5 masked
    @(posedge clk);
    tx_delay     <= 4'h4;
    fault_active <= 32'hffff_ffff;
    for (int t = 0; t < 1000 && fq.size() < 28; t++)
      @(posedge clk);
    check("frames", fq.size(), 28);
    k = 0;
    for (int b = 0; b < 32; b++)
      if (!(b inside {5, 27, 29, 30}) && k < fq.size())
      begin
        check("frame", fq[k], {1'b1, 5'(b), codes[b]});
        k++;
      end
    @(posedge clk);
    tx_delay         <= 4'h0;
    fault_active[25] <= 1'b0;
    for (int t = 0; t < 200 && fq.size() < 29; t++)
      @(posedge clk);
    settle(2);
    check("frames", fq.size(), 29);
    check("cleared", fq[28], {1'b0, 5'd25, 16'h0});
    check("errors", reported_errs, 32'h95ff_ffff);
    test_done;
  end
endmodule
`default_nettype wire
